// ### hw/cfr_readout_seq.sv
// Readout sequencer: channel stepping, driver routing, differential result and end-of-read flag
// Functional notes
// - Polarity pin 0 integrates up, 1 down
// - Outputs are references offset by the CDS difference
// - Driver 1 carries 63..32, driver 0 31..0
// - Parallel select low sequential, high simultaneous
// - Scan start pulse begins read, clears counter
// - Sequential: channel 63 on first edge after fall
// - Sequential: each driver steps every four clocks
// - Sequential: driver 0 lags driver 1 two clocks
// - Finished driver floats if enabled, else common-mode
// - Sequential data rate is half the clock
// - Simultaneous: pairs 31/63, 30/62 and downward
// - Simultaneous read of 64 channels in 33 clocks
// - Simultaneous: one result per driver per clock
// - End-of-read flag low while reading, else high
// - Next read waits for clear and start rising edges
`timescale 1ns/1ps
module cfr_readout_seq #(
	parameter int W = 16,
	parameter logic [W:0] LOW_REF = (W+1)'(16'h2000),
	parameter logic [W:0] HIGH_REF = (W+1)'(16'hA000),
	parameter logic [W:0] CM_LEVEL = (W+1)'(16'h6000)
) (
	input logic CLK,
	input logic RSTN,
	input logic SCAN_START_INPUT,
	input logic INTEGRATOR_CLEAR,
	input logic PARALLEL_READOUT_SELECT,
	input logic INTEGRATION_POLARITY_SELECT,
	input logic OUTPUT_FLOAT_ENABLE,
	input logic SAMPLE_WE,
	input logic [cfr_pkg::CH_W-1:0] SAMPLE_ADDR,
	input logic [W-1:0] SAMPLE_DIFF,
	output logic [W:0] DIFF_OUT_POSITIVE_1,
	output logic [W:0] DIFF_OUT_NEGATIVE_1,
	output logic DRIVER_OE_1,
	output logic [cfr_pkg::CH_W-1:0] CHAN_SEL_1,
	output logic [W:0] DIFF_OUT_POSITIVE_0,
	output logic [W:0] DIFF_OUT_NEGATIVE_0,
	output logic DRIVER_OE_0,
	output logic [cfr_pkg::CH_W-1:0] CHAN_SEL_0,
	output logic EOC_OUT,
	output logic INTEGRATE_DOWN
);
	import cfr_pkg::*;

	cfr_state_t state_q, state_d;
	logic sti_q, integrator_clear_q, integrator_clear_seen_q, par_q, pol_q, eoc_q;
	logic act1_q, act0_q, oe1_q, oe0_q;
	logic [TICK_W-1:0] tick_q;
	logic [CH_W-1:0] step_q, nxt1_q, nxt0_q, chan1_q, chan0_q;
	logic [W:0] pos1_q, neg1_q, pos0_q, neg0_q;
	logic [W-1:0] rd1, rd0;

	wire sti_rise = SCAN_START_INPUT & ~sti_q;
	wire sti_fall = ~SCAN_START_INPUT & sti_q;
	wire integrator_clear_rise = INTEGRATOR_CLEAR & ~integrator_clear_q;
	wire in_read = (state_q == ST_READ);
	wire [TICK_W-1:0] phase = tick_q & SEQ_PHASE_MASK;
	// A clear edge in the same cycle as the start edge counts, which allows the overlapped minimum scan
	wire rearm_ok = integrator_clear_seen_q | integrator_clear_rise;
	wire go_w = sti_rise & ((state_q == ST_IDLE) | ((state_q == ST_WAIT) & rearm_ok));
	wire launch_w = (state_q == ST_ARMED) & sti_fall;
	wire sim_run = in_read & par_q & (tick_q < SIM_DONE);
	wire seq1_w = in_read & ~par_q & (phase == SEQ_PHASE_DRV1) & (tick_q < SEQ_DONE1);
	wire seq0_w = in_read & ~par_q & (phase == SEQ_PHASE_DRV0) & (tick_q < SEQ_DONE0);
	wire upd1_w = launch_w | sim_run | seq1_w;
	wire upd0_w = (launch_w & par_q) | sim_run | seq0_w;
	wire end1_w = in_read & (tick_q == (par_q ? SIM_DONE : SEQ_DONE1));
	wire end0_w = in_read & (tick_q == (par_q ? SIM_DONE : SEQ_DONE0));
	// Prefetch: memory address is the next value, so the word is ready at the very next update
	wire [CH_W-1:0] nxt1_d = go_w ? CH_TOP1 : (upd1_w ? nxt1_q - CH_ONE : nxt1_q);
	wire [CH_W-1:0] nxt0_d = go_w ? CH_TOP0 : (upd0_w ? nxt0_q - CH_ONE : nxt0_q);
	wire [W:0] base_neg = (pol_q == POL_UP) ? LOW_REF : HIGH_REF;
	wire [W:0] base_pos = (pol_q == POL_UP) ? HIGH_REF : LOW_REF;
	wire [W:0] neg1_w = base_neg + {1'b0, rd1};
	wire [W:0] pos1_w = base_pos - {1'b0, rd1};
	wire [W:0] neg0_w = base_neg + {1'b0, rd0};
	wire [W:0] pos0_w = base_pos - {1'b0, rd0};
	wire rest1 = (~act1_q | end1_w) & ~upd1_w;
	wire rest0 = (~act0_q | end0_w) & ~upd0_w;
	wire read_d = (state_d == ST_ARMED) | (state_d == ST_READ);

	cfr_sample_mem #(.W(W), .AW(CH_W)) u_mem (
		.clk(CLK),
		.we(SAMPLE_WE),
		.waddr(SAMPLE_ADDR),
		.wdata(SAMPLE_DIFF),
		.raddr_a(nxt1_d),
		.raddr_b(nxt0_d),
		.rdata_a(rd1),
		.rdata_b(rd0)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (go_w) begin
					state_d = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (launch_w) begin
					state_d = ST_READ;
				end
			end
			ST_READ: begin
				// The controller may stop the clock from here on; nothing counts on later edges
				if (end0_w) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (go_w) begin
					state_d = ST_ARMED;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			state_q <= ST_IDLE;
			sti_q <= 1'b0;
			integrator_clear_q <= 1'b0;
			integrator_clear_seen_q <= 1'b0;
			par_q <= 1'b0;
			pol_q <= POL_UP;
			eoc_q <= 1'b1;
			tick_q <= '0;
			step_q <= '0;
			nxt1_q <= CH_TOP1;
			nxt0_q <= CH_TOP0;
		end else begin
			state_q <= state_d;
			sti_q <= SCAN_START_INPUT;
			integrator_clear_q <= INTEGRATOR_CLEAR;
			pol_q <= INTEGRATION_POLARITY_SELECT;
			eoc_q <= ~read_d;
			nxt1_q <= nxt1_d;
			nxt0_q <= nxt0_d;
			if (go_w) begin
				integrator_clear_seen_q <= 1'b0;
			end else if (integrator_clear_rise & (in_read | (state_q == ST_WAIT))) begin
				integrator_clear_seen_q <= 1'b1;
			end
			if (go_w) begin
				par_q <= PARALLEL_READOUT_SELECT;
			end
			if (launch_w) begin
				tick_q <= TICK_ONE;
			end else if (in_read) begin
				tick_q <= tick_q + TICK_ONE;
			end
			if (go_w) begin
				step_q <= '0;
			end else if (upd1_w) begin
				step_q <= step_q + CH_ONE;
			end
		end
	end

	// Channel state per driver; a driver that is not reading follows the float pin live
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			act1_q <= 1'b0;
			act0_q <= 1'b0;
			chan1_q <= CH_TOP1;
			chan0_q <= CH_TOP0;
		end else begin
			act1_q <= upd1_w | (act1_q & ~end1_w);
			act0_q <= upd0_w | (act0_q & ~end0_w);
			if (upd1_w) begin
				chan1_q <= nxt1_q;
			end
			if (upd0_w) begin
				chan0_q <= nxt0_q;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			pos1_q <= CM_LEVEL;
			neg1_q <= CM_LEVEL;
			oe1_q <= 1'b0;
		end else if (upd1_w) begin
			pos1_q <= pos1_w;
			neg1_q <= neg1_w;
			oe1_q <= 1'b1;
		end else if (rest1) begin
			pos1_q <= CM_LEVEL;
			neg1_q <= CM_LEVEL;
			oe1_q <= ~OUTPUT_FLOAT_ENABLE;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			pos0_q <= CM_LEVEL;
			neg0_q <= CM_LEVEL;
			oe0_q <= 1'b0;
		end else if (upd0_w) begin
			pos0_q <= pos0_w;
			neg0_q <= neg0_w;
			oe0_q <= 1'b1;
		end else if (rest0) begin
			pos0_q <= CM_LEVEL;
			neg0_q <= CM_LEVEL;
			oe0_q <= ~OUTPUT_FLOAT_ENABLE;
		end
	end

	assign DIFF_OUT_POSITIVE_1 = pos1_q;
	assign DIFF_OUT_NEGATIVE_1 = neg1_q;
	assign DRIVER_OE_1 = oe1_q;
	assign CHAN_SEL_1 = chan1_q;
	assign DIFF_OUT_POSITIVE_0 = pos0_q;
	assign DIFF_OUT_NEGATIVE_0 = neg0_q;
	assign DRIVER_OE_0 = oe0_q;
	assign CHAN_SEL_0 = chan0_q;
	assign EOC_OUT = eoc_q;
	assign INTEGRATE_DOWN = pol_q;

	wire [W:0] ref_sum = LOW_REF + HIGH_REF;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	AST_POLARITY: assert property ($past(RSTN) |-> INTEGRATE_DOWN == $past(INTEGRATION_POLARITY_SELECT))
		else $error("polarity output does not follow pin");
	AST_REF_SUM: assert property (act1_q && DRIVER_OE_1
		|-> (DIFF_OUT_POSITIVE_1 + DIFF_OUT_NEGATIVE_1) == ref_sum)
		else $error("driver 1 outputs not symmetric about references");
	AST_FIRST_63: assert property (launch_w && !par_q |=> CHAN_SEL_1 == CH_TOP1 && DRIVER_OE_1)
		else $error("channel 63 not driven after start fall");
	AST_STEP4: assert property (upd1_w && !par_q |=> ##1 $stable(CHAN_SEL_1) [*3])
		else $error("driver 1 stepped before four clocks");
	AST_SKEW2: assert property (upd1_w && !par_q |-> ##2 upd0_w)
		else $error("driver 0 not two clocks behind driver 1");
	AST_SIM_PAIR: assert property (in_read && par_q && act1_q && act0_q |-> CHAN_SEL_1 == CHAN_SEL_0 + CH_HALF)
		else $error("simultaneous pair mismatch");
	AST_SIM_33: assert property (launch_w && par_q |-> ##32 !EOC_OUT ##1 EOC_OUT)
		else $error("simultaneous read not done in 33 clocks");
	AST_EOC: assert property (((state_q == ST_ARMED) || (state_q == ST_READ)) == !EOC_OUT)
		else $error("end of read flag wrong");
	AST_FLOAT: assert property (state_q == ST_WAIT && $past(state_q) == ST_WAIT && $past(OUTPUT_FLOAT_ENABLE)
		|-> !DRIVER_OE_1 && !DRIVER_OE_0)
		else $error("finished drivers not floated");
	AST_DESCEND: assert property (act1_q && $past(act1_q) && $changed(CHAN_SEL_1)
		|-> CHAN_SEL_1 == $past(CHAN_SEL_1) - CH_ONE)
		else $error("driver 1 channel not descending by one");
	AST_START_CLEAR: assert property (go_w |=> step_q == '0 && !EOC_OUT)
		else $error("start did not clear counter");
	AST_WAIT_GATE: assert property (state_q == ST_WAIT && sti_rise && !integrator_clear_seen_q && !integrator_clear_rise
		|=> state_q == ST_WAIT)
		else $error("read restarted without clear edge");

	COV_SEQ_DONE: cover property (end0_w && !par_q);
	COV_SIM_DONE: cover property (end0_w && par_q);
	COV_REARM: cover property (state_q == ST_WAIT && go_w);
	COV_OVERLAP: cover property (go_w && integrator_clear_rise);
endmodule : cfr_readout_seq

// ### hw/cfr_pkg.sv
// Shared constants and types of the charge front end readout sequencer
package cfr_pkg;
	localparam int CHANNELS = 64;
	localparam int CH_W = 6;
	localparam logic [CH_W-1:0] CH_TOP1 = 6'h3F;
	localparam logic [CH_W-1:0] CH_TOP0 = 6'h1F;
	localparam logic [CH_W-1:0] CH_HALF = 6'h20;
	localparam logic [CH_W-1:0] CH_ONE = 6'h01;
	localparam int TICK_W = 8;
	localparam logic [TICK_W-1:0] TICK_ONE = 8'h01;
	localparam logic [TICK_W-1:0] SEQ_PHASE_MASK = 8'h03;
	localparam logic [TICK_W-1:0] SEQ_PHASE_DRV1 = 8'h00;
	localparam logic [TICK_W-1:0] SEQ_PHASE_DRV0 = 8'h02;
	localparam logic [TICK_W-1:0] SEQ_DONE1 = 8'h80;
	localparam logic [TICK_W-1:0] SEQ_DONE0 = 8'h82;
	localparam logic [TICK_W-1:0] SIM_DONE = 8'h20;
	localparam logic POL_UP = 1'b0;
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_READ, ST_WAIT} cfr_state_t;
endpackage : cfr_pkg

// ### hw/cfr_sample_mem.sv
// Channel result store with one write port and two registered read ports
`timescale 1ns/1ps
module cfr_sample_mem #(
	parameter int W = 16,
	parameter int AW = 6
) (
	input logic clk,
	input logic we,
	input logic [AW-1:0] waddr,
	input logic [W-1:0] wdata,
	input logic [AW-1:0] raddr_a,
	input logic [AW-1:0] raddr_b,
	output logic [W-1:0] rdata_a,
	output logic [W-1:0] rdata_b
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	// Reads return the old word on a same-cycle write; the sequencer reads every cycle, so it catches up
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_a <= mem[raddr_a];
		rdata_b <= mem[raddr_b];
	end
endmodule : cfr_sample_mem

// ### dv/cfr_ctrl_model.sv
// Controller model that issues scan-start pulses, with or without integrator clear
`timescale 1ns/1ps
module cfr_ctrl_model (
	input wire logic clk,
	output logic start,
	output logic clear
);
	initial begin
		start = 1'h0;
		clear = 1'h0;
	end
	// Clear rises with start for the shortest scan; a pulse without clear must not rearm a waiting device
	task automatic pulse(input logic with_clr);
		@(negedge clk);
		start = 1'h1;
		clear = with_clr;
		@(negedge clk);
		start = 1'h0;
		clear = 1'h0;
	endtask : pulse
endmodule : cfr_ctrl_model

// ### dv/test_cfr_readout_seq.sv
// Self-checking bench of the readout sequencer
`timescale 1ns/1ps
module test_cfr_readout_seq;
	import cfr_pkg::*;
	localparam logic [16:0] LO = 17'h02000;
	localparam logic [16:0] HI = 17'h0A000;
	localparam logic [16:0] CM = 17'h06000;
	typedef struct packed {logic par; logic pol; logic flt;} cfr_row_t;
	cfr_row_t rows [4] = '{'{1'h0, 1'h0, 1'h1}, '{1'h0, 1'h1, 1'h0}, '{1'h1, 1'h0, 1'h0}, '{1'h1, 1'h1, 1'h1}};
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic par = 1'h0;
	logic pol = 1'h0;
	logic flt = 1'h0;
	logic we = 1'h0;
	logic [5:0] addr = 6'h00;
	logic [15:0] diff = 16'h0000;
	logic sta, clr, oe1, oe0, eoc, idn;
	logic [16:0] p1, n1, p0, n0;
	logic [5:0] s1, s0;
	int bad_count = 0;
	int check_count = 0;

	cfr_ctrl_model u_ctrl (.clk(clk), .start(sta), .clear(clr));
	cfr_readout_seq #(.W(16), .LOW_REF(LO), .HIGH_REF(HI), .CM_LEVEL(CM)) u_dut (
		.CLK(clk), .RSTN(rstn), .SCAN_START_INPUT(sta), .INTEGRATOR_CLEAR(clr),
		.PARALLEL_READOUT_SELECT(par), .INTEGRATION_POLARITY_SELECT(pol), .OUTPUT_FLOAT_ENABLE(flt),
		.SAMPLE_WE(we), .SAMPLE_ADDR(addr), .SAMPLE_DIFF(diff),
		.DIFF_OUT_POSITIVE_1(p1), .DIFF_OUT_NEGATIVE_1(n1), .DRIVER_OE_1(oe1), .CHAN_SEL_1(s1),
		.DIFF_OUT_POSITIVE_0(p0), .DIFF_OUT_NEGATIVE_0(n0), .DRIVER_OE_0(oe0), .CHAN_SEL_0(s0),
		.EOC_OUT(eoc), .INTEGRATE_DOWN(idn));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk_w(input logic [16:0] got, input logic [16:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected word at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_w

	task automatic chk_b(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_b

	// Channel data is distinct per channel so a skipped or repeated step shows as a wrong word
	function automatic logic [16:0] expw(input int ch, input logic up_down, input logic neg);
		logic [16:0] d;
		d = {1'h0, 16'h0400 + 16'(ch) * 16'h0111};
		if (neg) return (up_down ? HI : LO) + d;
		return (up_down ? LO : HI) - d;
	endfunction : expw

	task automatic chk_drv(input logic oe, input logic [16:0] p, input logic [16:0] n, input logic [5:0] s,
			input logic on, input int ch, input logic up_down, input logic fl);
		if (on) begin
			chk_b(oe, 1'h1);
			chk_w({11'h000, s}, 17'(ch));
			chk_w(p, expw(ch, up_down, 1'h0));
			chk_w(n, expw(ch, up_down, 1'h1));
		end else begin
			chk_b(oe, ~fl);
			if (!fl) begin
				chk_w(p, CM);
				chk_w(n, CM);
			end
		end
	endtask : chk_drv

	// A poke raises start and flips the mode pin mid-read; both must be ignored
	task automatic run(input cfr_row_t r, input int poke);
		@(negedge clk);
		par = r.par;
		pol = r.pol;
		flt = r.flt;
		u_ctrl.pulse(1'h1);
		for (int t = 0; t <= (r.par ? 35 : 133); t++) begin
			@(negedge clk);
			if (t == poke) begin
				u_ctrl.start = 1'h1;
				par = ~par;
			end
			if (t == poke + 1) u_ctrl.start = 1'h0;
			if (r.par) begin
				chk_drv(oe1, p1, n1, s1, t < 32, 63 - t, r.pol, r.flt);
				chk_drv(oe0, p0, n0, s0, t < 32, 31 - t, r.pol, r.flt);
				chk_b(eoc, t >= 32);
			end else begin
				chk_drv(oe1, p1, n1, s1, t < 128, 63 - t / 4, r.pol, r.flt);
				chk_drv(oe0, p0, n0, s0, t >= 2 && t < 130, 31 - (t - 2) / 4, r.pol, r.flt);
				chk_b(eoc, t >= 130);
			end
			chk_b(idn, r.pol);
		end
	endtask : run

	initial begin
		#(3000 * 25);
		bad_count++;
		wrap_up();
	end

	initial begin
		repeat (4) @(negedge clk);
		chk_b(eoc, 1'h1);
		chk_b(oe1, 1'h0);
		chk_b(oe0, 1'h0);
		chk_w({11'h000, s1}, {11'h000, CH_TOP1});
		chk_w({11'h000, s0}, {11'h000, CH_TOP0});
		rstn = 1'h1;
		for (int ch = 0; ch < 64; ch++) begin
			@(negedge clk);
			we = 1'h1;
			addr = 6'(ch);
			diff = 16'h0400 + 16'(ch) * 16'h0111;
		end
		@(negedge clk);
		we = 1'h0;
		foreach (rows[i]) run(rows[i], -1);
		u_ctrl.pulse(1'h0);
		repeat (4) begin
			@(negedge clk);
			chk_b(eoc, 1'h1);
		end
		run(rows[1], 20);
		pol = 1'h1;
		u_ctrl.pulse(1'h1);
		repeat (10) @(negedge clk);
		rstn = 1'h0;
		@(negedge clk);
		chk_b(eoc, 1'h1);
		chk_b(oe1, 1'h0);
		chk_b(idn, 1'h0);
		rstn = 1'h1;
		run(rows[2], -1);
		wrap_up();
	end
endmodule : test_cfr_readout_seq
